// *** shared/lsv_pkg.sv ***
// Package of the line-side validation and gain register group.
// Assumes an APB slave with 32-bit data and one word per register.
package lsv_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_VALIDATION = 8'h0e;
  localparam logic [7:0] IDX_GAIN = 8'h0f;
  localparam logic [7:0] IDX_INTL_ONE = 8'h10;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_VALIDATION = 8'h04;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_INTL_ONE = 8'h08;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int VAL_PENDING_BIT = 2;
  localparam int VAL_RUNNING_BIT = 1;
  localparam int VAL_RESULT_BIT = 0;
  localparam int GAIN_TX_MUTE_BIT = 7;
  localparam int GAIN_TX_ATT_LSB = 4;
  localparam int GAIN_RX_MUTE_BIT = 3;
  localparam int GAIN_RX_SEL_LSB = 0;
  localparam int INTL_TERM_OFF_BIT = 7;
  localparam int INTL_ONHOOK_SPEED_BIT = 6;
  localparam int INTL_AC_TERM_BIT = 5;
  localparam int INTL_DC_TERM_LSB = 2;
  localparam int INTL_RING_THR_LSB = 0;
  localparam logic [7:0] INTL_WRITE_MASK = 8'hef;

  // ****************************************************************
  // On-hook counter lengths in sample periods
  // ****************************************************************
  localparam logic [12:0] ONHOOK_FAST_SAMPLES = 13'h0400;
  localparam logic [12:0] ONHOOK_SLOW_SAMPLES = 13'h1000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {VFY_IDLE, VFY_RUN, VFY_DONE} lsv_vfy_t;

  typedef struct packed {
    lsv_vfy_t vfy;
    logic bad_part;
    logic [7:0] gain;
    logic [7:0] intl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic data_enable;
    logic tx_mute;
    logic [3:0] tx_atten_db;
    logic rx_mute;
    logic [3:0] rx_gain_db;
    logic [5:0] mon_atten_tenth_db;
    logic [12:0] onhook_samples;
    logic ac_complex;
    logic term_off_or_squelch;
    logic [1:0] dc_termination_sel;
    logic [1:0] ring_threshold_sel;
  } lsv_state_t;

endpackage

// *** rtl/lsv_regs.sv ***
// Line-side validation status, gain control and international control
// registers behind an APB slave, with decoded settings driven out.
// Assumes the link logic reports the line-side identity as a pulse with a
// match flag, and that all inputs are synchronous to CLK.
//
// How it works
// - First enable starts automatic line-side identity check
// - Pending bit reads 1 until check completes
// - Running bit reads 1 while check runs
// - Result 1 means wrong part; data suppressed
// - Gain bit 7 mutes transmit path
// - Bits 6:4 select transmit attenuation, 11x 12dB
// - Gain bit 3 mutes receive path
// - Bits 2:0 select receive gain, 1xx 12dB
// - Same bits select on-hook monitor attenuation
// - Gain register resets to all zeros
// - International control resets to 0x08 with fields
// - On-hook speed picks 1024 or 4096 samples
// - AC termination bit selects real or complex
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lsv_regs (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LS_ENABLE,
  input wire logic LS_ID_VALID,
  input wire logic LS_ID_OK,
  output logic DATA_ENABLE,
  output logic TX_MUTE,
  output logic [3:0] TX_ATTEN_DB,
  output logic RX_MUTE,
  output logic [3:0] RX_GAIN_DB,
  output logic [5:0] MON_ATTEN_TENTH_DB,
  output logic [12:0] ONHOOK_SAMPLES,
  output logic AC_COMPLEX,
  output logic TERM_OFF_OR_SQUELCH,
  output logic [1:0] DC_TERMINATION_SEL,
  output logic [1:0] RING_THRESHOLD_SEL
);

  // ****************************************************************
  // Decoders
  // ****************************************************************
  function automatic logic [3:0] tx_atten_decode(input logic [2:0] sel);
    case (sel)
      3'h0: tx_atten_decode = 4'h0;
      3'h1: tx_atten_decode = 4'h3;
      3'h2: tx_atten_decode = 4'h6;
      3'h3: tx_atten_decode = 4'h9;
      3'h6, 3'h7: tx_atten_decode = 4'hc;
      // Codes 10x have no defined setting; they fall back to 0 dB.
      default: tx_atten_decode = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] rx_gain_decode(input logic [2:0] sel);
    if (sel[2])
    begin
      rx_gain_decode = 4'hc;
    end
    else
    begin
      case (sel[1:0])
        2'h0: rx_gain_decode = 4'h0;
        2'h1: rx_gain_decode = 4'h3;
        2'h2: rx_gain_decode = 4'h6;
        default: rx_gain_decode = 4'h9;
      endcase
    end
  endfunction

  // The monitor steps are not whole decibels, so the result is given in
  // tenths of a decibel.
  function automatic logic [5:0] mon_atten_decode(input logic [2:0] sel);
    if (sel[2])
    begin
      mon_atten_decode = 6'h32;
    end
    else
    begin
      case (sel[1:0])
        2'h0: mon_atten_decode = 6'h00;
        2'h1: mon_atten_decode = 6'h0a;
        2'h2: mon_atten_decode = 6'h16;
        default: mon_atten_decode = 6'h23;
      endcase
    end
  endfunction

  // Registers sit one per aligned word, so the index moves up two bits.
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'h0};
  endfunction

  // One-hot register select: bit 0 validation, bit 1 gain, bit 2
  // international control; no bit is set for an unmapped address.
  function automatic logic [2:0] reg_select(input logic [7:0] addr);
    reg_select = 3'h0;
    if (addr == byte_addr(lsv_pkg::IDX_VALIDATION))
    begin
      reg_select[0] = 1'b1;
    end
    if (addr == byte_addr(lsv_pkg::IDX_GAIN))
    begin
      reg_select[1] = 1'b1;
    end
    if (addr == byte_addr(lsv_pkg::IDX_INTL_ONE))
    begin
      reg_select[2] = 1'b1;
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  lsv_pkg::lsv_state_t s_q;
  lsv_pkg::lsv_state_t s_d;
  logic [7:0] val_view;
  logic [2:0] hit;
  logic setup;
  logic access;

  always_comb
  begin
    s_d = s_q;
    hit = reg_select(PADDR);
    setup = PSEL && !PENABLE;
    access = PSEL && PENABLE && s_q.pready;
    // Status bits are built afresh each cycle from the check state.
    val_view = 8'h00;
    val_view[lsv_pkg::VAL_PENDING_BIT] =
      (s_q.vfy != lsv_pkg::VFY_DONE);
    val_view[lsv_pkg::VAL_RUNNING_BIT] =
      (s_q.vfy == lsv_pkg::VFY_RUN);
    val_view[lsv_pkg::VAL_RESULT_BIT] = s_q.bad_part;

    // ****************************************************************
    // Identity check
    // ****************************************************************
    // The check runs once, on the first enable only. A part swapped
    // later is not caught until the next reset, which keeps the result
    // bit steady for software that has already read it.
    case (s_q.vfy)
      lsv_pkg::VFY_IDLE:
      begin
        if (LS_ENABLE)
        begin
          s_d.vfy = lsv_pkg::VFY_RUN;
        end
      end
      lsv_pkg::VFY_RUN:
      begin
        // The match flag counts only in the cycle of the result pulse.
        if (LS_ID_VALID)
        begin
          s_d.vfy = lsv_pkg::VFY_DONE;
          s_d.bad_part = !LS_ID_OK;
        end
      end
      lsv_pkg::VFY_DONE:
      begin
        s_d.vfy = lsv_pkg::VFY_DONE;
      end
      default:
      begin
        s_d.vfy = lsv_pkg::VFY_IDLE;
      end
    endcase

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Read data and error are prepared in the setup cycle, so every
    // access phase completes in its first cycle. The error flag is
    // cleared in every other cycle, so it stands only beside PREADY.
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    if (setup)
    begin
      s_d.prdata = 32'h0000_0000;
      if (hit[0])
      begin
        s_d.prdata[7:0] = val_view;
        // The validation register is read-only; a write is refused.
        s_d.pslverr = PWRITE;
      end
      else if (hit[1])
      begin
        s_d.prdata[7:0] = s_q.gain;
      end
      else if (hit[2])
      begin
        s_d.prdata[7:0] = s_q.intl;
      end
      else
      begin
        s_d.pslverr = 1'b1;
      end
    end

    if (access && PWRITE && !s_q.pslverr)
    begin
      if (hit[1])
      begin
        s_d.gain = PWDATA[7:0];
      end
      if (hit[2])
      begin
        // Reserved bit 4 is masked so that it always reads zero.
        s_d.intl = PWDATA[7:0] & lsv_pkg::INTL_WRITE_MASK;
      end
    end

    // ****************************************************************
    // Decoded settings
    // ****************************************************************
    // Decoded outputs follow the stored registers one cycle later; the
    // extra cycle keeps every output straight from a flip-flop.
    s_d.data_enable = (s_q.vfy == lsv_pkg::VFY_DONE) && !s_q.bad_part;
    s_d.tx_mute = s_q.gain[lsv_pkg::GAIN_TX_MUTE_BIT];
    s_d.tx_atten_db = tx_atten_decode(
      s_q.gain[lsv_pkg::GAIN_TX_ATT_LSB +: 3]);
    s_d.rx_mute = s_q.gain[lsv_pkg::GAIN_RX_MUTE_BIT];
    s_d.rx_gain_db = rx_gain_decode(
      s_q.gain[lsv_pkg::GAIN_RX_SEL_LSB +: 3]);
    s_d.mon_atten_tenth_db = mon_atten_decode(
      s_q.gain[lsv_pkg::GAIN_RX_SEL_LSB +: 3]);
    // Only the counter length is chosen here; the count runs elsewhere.
    s_d.onhook_samples = s_q.intl[lsv_pkg::INTL_ONHOOK_SPEED_BIT] ?
      lsv_pkg::ONHOOK_SLOW_SAMPLES : lsv_pkg::ONHOOK_FAST_SAMPLES;
    s_d.ac_complex = s_q.intl[lsv_pkg::INTL_AC_TERM_BIT];
    s_d.term_off_or_squelch = s_q.intl[lsv_pkg::INTL_TERM_OFF_BIT];
    s_d.dc_termination_sel = s_q.intl[lsv_pkg::INTL_DC_TERM_LSB +: 2];
    s_d.ring_threshold_sel = s_q.intl[lsv_pkg::INTL_RING_THR_LSB +: 2];
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    // Decoded outputs reset to what the register reset values decode
    // to, so nothing downstream sees a setting software never chose.
    if (!RSTN)
    begin
      s_q.vfy <= lsv_pkg::VFY_IDLE;
      s_q.bad_part <= 1'b0;
      s_q.gain <= lsv_pkg::RST_GAIN;
      s_q.intl <= lsv_pkg::RST_INTL_ONE;
      s_q.prdata <= 32'h0000_0000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.data_enable <= 1'b0;
      s_q.tx_mute <= 1'b0;
      s_q.tx_atten_db <= 4'h0;
      s_q.rx_mute <= 1'b0;
      s_q.rx_gain_db <= 4'h0;
      s_q.mon_atten_tenth_db <= 6'h00;
      s_q.onhook_samples <= lsv_pkg::ONHOOK_FAST_SAMPLES;
      s_q.ac_complex <= 1'b0;
      s_q.term_off_or_squelch <= 1'b0;
      s_q.dc_termination_sel <=
        lsv_pkg::RST_INTL_ONE[lsv_pkg::INTL_DC_TERM_LSB +: 2];
      s_q.ring_threshold_sel <= 2'h0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a plain copy of a state bit, so none can glitch.
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign DATA_ENABLE = s_q.data_enable;
  assign TX_MUTE = s_q.tx_mute;
  assign TX_ATTEN_DB = s_q.tx_atten_db;
  assign RX_MUTE = s_q.rx_mute;
  assign RX_GAIN_DB = s_q.rx_gain_db;
  assign MON_ATTEN_TENTH_DB = s_q.mon_atten_tenth_db;
  assign ONHOOK_SAMPLES = s_q.onhook_samples;
  assign AC_COMPLEX = s_q.ac_complex;
  assign TERM_OFF_OR_SQUELCH = s_q.term_off_or_squelch;
  assign DC_TERMINATION_SEL = s_q.dc_termination_sel;
  assign RING_THRESHOLD_SEL = s_q.ring_threshold_sel;

endmodule

`default_nettype wire

// *** sim/lsv_line_side.sv ***
// Model of the line-side chip answering the identity check.
// Assumes the same clock and reset as the register group.
`timescale 1ns/1ps
`default_nettype none
module lsv_line_side #(
  parameter int DELAY = 12
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic LS_ENABLE,
  input wire logic BAD,
  output logic LS_ID_VALID,
  output logic LS_ID_OK
);
  logic [7:0] cnt_q;
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cnt_q <= 8'h00;
      LS_ID_VALID <= 1'b0;
    end
    else
    begin
      LS_ID_VALID <= LS_ENABLE && cnt_q == 8'(DELAY - 1);
      if (LS_ENABLE && cnt_q < 8'(DELAY))
        cnt_q <= cnt_q + 8'h01;
    end
  end
  // Outside the pulse the flag shows the wrong answer on purpose.
  assign LS_ID_OK = LS_ID_VALID ? !BAD : BAD;
endmodule
`default_nettype wire

// *** sim/lsv_regs_monitor.sv ***
// Assertions on the APB answer and the decoded settings.
// Assumes it is bound to the register group.
`timescale 1ns/1ps
`default_nettype none
module lsv_regs_monitor (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic LS_ID_VALID,
  input wire logic LS_ID_OK,
  input wire logic DATA_ENABLE,
  input wire logic TX_MUTE,
  input wire logic [3:0] TX_ATTEN_DB,
  input wire logic RX_MUTE,
  input wire logic [12:0] ONHOOK_SAMPLES,
  input wire logic AC_COMPLEX
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence wr_gain;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h3c;
  endsequence
  sequence wr_intl;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h40;
  endsequence
  function automatic logic [3:0] tx_db(input logic [2:0] s);
    return s[2] ? (s[1] ? 4'hc : 4'h0) : 4'(s) * 4'h3;
  endfunction
  ready_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("No ready in access cycle");
  ro_refused_a: assert property (PSEL && !PENABLE && PWRITE &&
    PADDR == 8'h38 |=> PSLVERR) else $error("Read-only write taken");
  tx_mute_a: assert property (wr_gain |=> ##1
    TX_MUTE == $past(PWDATA[7], 2)) else $error("Tx mute wrong");
  rx_mute_a: assert property (wr_gain |=> ##1
    RX_MUTE == $past(PWDATA[3], 2)) else $error("Rx mute wrong");
  tx_att_a: assert property (wr_gain |=> ##1
    TX_ATTEN_DB == tx_db($past(PWDATA[6:4], 2)))
    else $error("Tx attenuation wrong");
  onhook_len_a: assert property (wr_intl |=> ##1
    ONHOOK_SAMPLES == ($past(PWDATA[6], 2) ? 13'h1000 : 13'h0400))
    else $error("On-hook count wrong");
  ac_term_a: assert property (wr_intl |=> ##1
    AC_COMPLEX == $past(PWDATA[5], 2)) else $error("AC select wrong");
  data_gate_a: assert property ($rose(DATA_ENABLE) |->
    $past(LS_ID_VALID, 2) && $past(LS_ID_OK, 2))
    else $error("Data enabled without good check");
endmodule
bind lsv_regs lsv_regs_monitor MON (.CLK(CLK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LS_ID_VALID(LS_ID_VALID), .LS_ID_OK(LS_ID_OK),
  .DATA_ENABLE(DATA_ENABLE), .TX_MUTE(TX_MUTE),
  .TX_ATTEN_DB(TX_ATTEN_DB), .RX_MUTE(RX_MUTE),
  .ONHOOK_SAMPLES(ONHOOK_SAMPLES), .AC_COMPLEX(AC_COMPLEX));
`default_nettype wire

// *** sim/lsv_regs_test.sv ***
// Bench of the register group: APB calls with expected values.
// Assumes the line-side model answers the check after a delay.
`timescale 1ns/1ps
`default_nettype none
module lsv_regs_test;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, en = 0, bad = 0;
  logic [7:0] pa = 0, g;
  logic [31:0] pwd = 0, prd, r, e;
  logic rdy, err, vld, ok, de, tx_mute, rx_mute, ac, term;
  logic [3:0] txa, rxg;
  logic [5:0] mon;
  logic [12:0] ons;
  logic [1:0] dc_sel, rts;
  logic [31:0] mt [4] = '{32'h0, 32'ha, 32'h16, 32'h23};
  int fails = 0, compares = 0, cyc = 0;
  always #4 clk = ~clk;
  lsv_regs DUT (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy),
    .PSLVERR(err), .LS_ENABLE(en), .LS_ID_VALID(vld), .LS_ID_OK(ok),
    .DATA_ENABLE(de), .TX_MUTE(tx_mute), .TX_ATTEN_DB(txa),
    .RX_MUTE(rx_mute),
    .RX_GAIN_DB(rxg), .MON_ATTEN_TENTH_DB(mon), .ONHOOK_SAMPLES(ons),
    .AC_COMPLEX(ac), .TERM_OFF_OR_SQUELCH(term),
    .DC_TERMINATION_SEL(dc_sel), .RING_THRESHOLD_SEL(rts));
  lsv_line_side FAR (.CLK(clk), .RSTN(rstn), .LS_ENABLE(en), .BAD(bad),
    .LS_ID_VALID(vld), .LS_ID_OK(ok));
  task automatic print_verdict();
    $display("Compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1)
      @(posedge clk);
    r = prd;
    e = 32'(err);
    psel <= 0;
    pen <= 0;
  endtask
  // Settle: outputs follow a write one edge after it is stored.
  task automatic st();
    @(posedge clk);
    #1;
  endtask
  task automatic rst();
    rstn <= 0;
    en <= 0;
    repeat (10) @(posedge clk);
    rstn <= 1;
  endtask
  task automatic poll();
    xf(0, 8'h38, 0);
    while (r[2:1] !== 2'b00)
      xf(0, 8'h38, 0);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    rst();
    xf(0, 8'h38, 0);
    check_eq(r, 32'h4);
    xf(0, 8'h3c, 0);
    check_eq(r, 32'h0);
    xf(0, 8'h40, 0);
    check_eq(r, 32'h8);
    check_eq(32'({dc_sel, ons}), 32'h4400);
    en <= 1;
    xf(0, 8'h38, 0);
    check_eq(r, 32'h6);
    poll();
    check_eq(r, 32'h0);
    st();
    check_eq(32'(de), 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      g = {i[0], i[2:0], ~i[0], i[2:0]};
      xf(1, 8'h3c, 32'(g));
      st();
      check_eq(32'({tx_mute, rx_mute}), 32'({g[7], g[3]}));
      check_eq(32'(txa), g[6] ? (g[5] ? 32'hc : 0) : 32'(g[5:4]) * 3);
      check_eq(32'(rxg), g[2] ? 32'hc : 32'(g[1:0]) * 3);
      check_eq(32'(mon), g[2] ? 32'h32 : mt[g[1:0]]);
      xf(0, 8'h3c, 0);
      check_eq(r, 32'(g));
    end
    xf(1, 8'h40, 32'hff);
    xf(0, 8'h40, 0);
    check_eq(r, 32'hef);
    check_eq(32'({term, ac, dc_sel, rts}), 32'h3f);
    check_eq(32'(ons), 32'h1000);
    xf(1, 8'h40, 32'h0);
    st();
    check_eq(32'({ac, ons}), 32'h400);
    xf(1, 8'h38, 32'h7);
    check_eq(e, 32'h1);
    xf(0, 8'h38, 0);
    check_eq(r, 32'h0);
    xf(0, 8'h44, 0);
    check_eq(r | e, 32'h1);
    bad <= 1;
    rst();
    en <= 1;
    poll();
    check_eq(r, 32'h1);
    st();
    check_eq(32'(de), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
